// >>> rtl/dpw_pkg.sv
// package: register map, field layout and types for the dual pwm deadband timer
package dpw_pkg;

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] CTL0_OFF   = 8'h00;
    localparam logic [7:0] CTL1_OFF   = 8'h04;
    localparam logic [7:0] COUNT_OFF  = 8'h08;
    localparam logic [7:0] PWMV_OFF   = 8'h0c;
    localparam logic [7:0] RELOAD_OFF = 8'h10;
    localparam logic [7:0] DEAD_OFF   = 8'h14;
    localparam logic [7:0] STAT_OFF   = 8'h18;

    // ---------------------------------------------------------------
    // field positions of the first control register
    // ---------------------------------------------------------------
    localparam int CTL0_EN_BIT       = 7;
    localparam int CTL0_POL_BIT      = 6;
    localparam int CTL0_PRES_LSB     = 3;
    localparam int CTL0_MODE_LSB     = 0;
    // field positions of timer_control_second
    localparam int CTL1_MODEHI_BIT   = 0;

    // ---------------------------------------------------------------
    // mode codes (low three bits plus mode_extension_bit)
    // ---------------------------------------------------------------
    localparam logic [2:0] MODE_LO_DUAL = 3'h4;
    localparam logic       MODE_HI_DUAL = 1'b1;

    // ---------------------------------------------------------------
    // reset values and the count restart value
    // ---------------------------------------------------------------
    localparam logic [7:0]  CTL0_RST   = 8'h00;
    localparam logic [15:0] COUNT_RST  = 16'h0001;
    localparam logic [15:0] PWMV_RST   = 16'h0000;
    localparam logic [15:0] RELOAD_RST = 16'hffff;
    localparam logic [7:0]  DEAD_RST   = 8'h00;
    localparam logic [15:0] COUNT_RESTART = 16'h0001;

    typedef struct packed {
        logic        enable;
        logic        polarity;
        logic [2:0]  prescale;
        logic [2:0]  mode;
    } dpw_ctl0_s;

    typedef struct packed {
        logic        pwm_true;
        logic        pwm_comp;
        logic        comp_sel;
    } dpw_pins_s;

    typedef enum logic [1:0] {
        DPW_IDLE,
        DPW_FIRST,
        DPW_RUN
    } dpw_state_e;

endpackage

// >>> rtl/dpw_presc.sv
// prescaler producing one tick every 2^sel clocks
`timescale 1ns/100ps
module dpw_presc
    import dpw_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire logic       run_i,
    input  wire logic [2:0] sel_i,
    output logic            tick_o
);
    logic [6:0] div_reg;

    // ---------------------------------------------------------------
    // divider
    // ---------------------------------------------------------------
    // prescale factor
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_reg <= 7'h00;
        end else if (!run_i) begin
            div_reg <= 7'h00;
        end else if (div_reg >= 7'((1 << sel_i) - 1)) begin
            div_reg <= 7'h00;
        end else begin
            div_reg <= div_reg + 7'h01;
        end
    end

    assign tick_o = run_i && (div_reg >= 7'((1 << sel_i) - 1));

    property p_tick_period;
        @(posedge core_clk_i) disable iff (reset_i)
        (tick_o && sel_i == 3'h0 && $past(sel_i) == 3'h0 && $past(run_i)) |-> $past(tick_o);
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("prescale one tick not every cycle");
endmodule

// >>> rtl/dpw_dead.sv
// deadband generator for the complementary output
`timescale 1ns/100ps
module dpw_dead
    import dpw_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire logic       run_i,
    input  wire logic       true_i,
    input  wire logic       pol_i,
    input  wire logic [7:0] dead_i,
    output logic            comp_o
);
    logic       true_d_reg;
    logic [7:0] dcnt_reg;

    // ---------------------------------------------------------------
    // deadband counter
    // ---------------------------------------------------------------
    // deadband after edge
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            true_d_reg <= 1'b0;
            dcnt_reg   <= 8'h00;
            comp_o     <= 1'b0;
        end else begin
            true_d_reg <= true_i;
            if (!run_i) begin
                dcnt_reg <= 8'h00;
                comp_o   <= pol_i;
            end else if (true_i != true_d_reg) begin
                dcnt_reg <= dead_i;
                comp_o   <= pol_i;
            end else if (dcnt_reg != 8'h00) begin
                dcnt_reg <= dcnt_reg - 8'h01;
                comp_o   <= pol_i;
            end else begin
                comp_o   <= ~true_i;
            end
        end
    end

    property p_dead_inactive;
        @(posedge core_clk_i) disable iff (reset_i)
        (run_i && $past(run_i) && true_i != $past(true_i)) |=> comp_o == $past(pol_i);
    endproperty
    a_dead_inactive: assert property (p_dead_inactive)
        else $error("complement active right after true edge");
endmodule

// >>> rtl/dpw_timer.sv
// dual output pwm timer with deadband and apb register slave
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/100ps

// Summary of operation
// - loaded count affects first pass only; later passes restart at 0001h
// - first period counts from loaded value to reload when start differs
// - dual mode switches shared pin to complementary output
// - period equals reload times prescale over clock frequency
module dpw_timer
    import dpw_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             pwm_true_o,
    output logic             pwm_comp_o,
    output logic             comp_sel_o,
    output logic             reload_evt_o
);
    import dpw_pkg::*;

    dpw_ctl0_s   ctl0_reg;
    logic        modehi_reg;
    logic [15:0] count_reg;
    logic [15:0] pwmv_reg;
    logic [15:0] reload_reg;
    logic [7:0]  dead_reg;
    dpw_state_e  state_reg;
    logic        true_reg;
    logic        true_dly_reg;
    logic        tick;
    logic        comp_w;
    logic        dual;
    logic        wr_en;
    logic        rd_en;

    function automatic logic decode_hit(input logic [7:0] a);
        decode_hit = (a == CTL0_OFF) || (a == CTL1_OFF) || (a == COUNT_OFF) ||
                     (a == PWMV_OFF) || (a == RELOAD_OFF) || (a == DEAD_OFF) ||
                     (a == STAT_OFF);
    endfunction

    assign wr_en = psel_i && penable_i && pwrite_i;
    assign rd_en = psel_i && penable_i && !pwrite_i;
    assign dual  = (ctl0_reg.mode == MODE_LO_DUAL) && (modehi_reg == MODE_HI_DUAL);

    // ---------------------------------------------------------------
    // apb register writes
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctl0_reg   <= dpw_ctl0_s'(CTL0_RST);
            modehi_reg <= 1'b0;
            pwmv_reg   <= PWMV_RST;
            reload_reg <= RELOAD_RST;
            dead_reg   <= DEAD_RST;
        end else if (wr_en) begin
            unique case (paddr_i)
                CTL0_OFF:   ctl0_reg   <= dpw_ctl0_s'(pwdata_i[7:0]);
                CTL1_OFF:   modehi_reg <= pwdata_i[CTL1_MODEHI_BIT];
                PWMV_OFF:   pwmv_reg   <= pwdata_i[15:0];
                RELOAD_OFF: reload_reg <= pwdata_i[15:0];
                DEAD_OFF:   dead_reg   <= pwdata_i[7:0];
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // apb answer
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !decode_hit(paddr_i);
            prdata_o  <= 32'h0000_0000;
            if (psel_i && !penable_i && !pwrite_i) begin
                unique case (paddr_i)
                    CTL0_OFF:   prdata_o <= {24'h000000, ctl0_reg};
                    CTL1_OFF:   prdata_o <= {31'h0, modehi_reg};
                    COUNT_OFF:  prdata_o <= {16'h0000, count_reg};
                    PWMV_OFF:   prdata_o <= {16'h0000, pwmv_reg};
                    RELOAD_OFF: prdata_o <= {16'h0000, reload_reg};
                    DEAD_OFF:   prdata_o <= {24'h000000, dead_reg};
                    STAT_OFF:   prdata_o <= {29'h0, pwm_comp_o, pwm_true_o, dual};
                    default:    prdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // prescaler
    // ---------------------------------------------------------------
    dpw_presc u_presc (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .run_i      (ctl0_reg.enable),
        .sel_i      (ctl0_reg.prescale),
        .tick_o     (tick)
    );

    // ---------------------------------------------------------------
    // counter and pass state
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            count_reg <= COUNT_RST;
            state_reg <= DPW_IDLE;
        end else if (wr_en && paddr_i == COUNT_OFF && !ctl0_reg.enable) begin
            count_reg <= pwdata_i[15:0];
            state_reg <= DPW_IDLE;
        end else if (!ctl0_reg.enable) begin
            state_reg <= DPW_IDLE;
        end else begin
            unique case (state_reg)
                DPW_IDLE: state_reg <= DPW_FIRST;
                DPW_FIRST, DPW_RUN: begin
                    if (tick) begin
                        if (count_reg >= reload_reg) begin
                            count_reg <= COUNT_RESTART;
                            state_reg <= DPW_RUN;
                        end else begin
                            count_reg <= count_reg + 16'h0001;
                        end
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // true output, reload event and complement
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            true_reg     <= 1'b0;
            reload_evt_o <= 1'b0;
        end else begin
            reload_evt_o <= ctl0_reg.enable && tick && (count_reg >= reload_reg);
            if (!ctl0_reg.enable) begin
                true_reg <= ctl0_reg.polarity;
            end else if (tick && count_reg >= reload_reg) begin
                true_reg <= ctl0_reg.polarity;
            end else if (tick && count_reg == pwmv_reg) begin
                true_reg <= ~ctl0_reg.polarity;
            end
        end
    end

    dpw_dead u_dead (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .run_i      (ctl0_reg.enable && dual),
        .true_i     (true_reg),
        .pol_i      (ctl0_reg.polarity),
        .dead_i     (dead_reg),
        .comp_o     (comp_w)
    );

    // ---------------------------------------------------------------
    // output pins
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            true_dly_reg <= 1'b0;
            pwm_true_o   <= 1'b0;
            pwm_comp_o   <= 1'b0;
            comp_sel_o   <= 1'b0;
        end else begin
            true_dly_reg <= true_reg;
            pwm_true_o   <= true_dly_reg;
            pwm_comp_o <= comp_w;
            comp_sel_o <= dual;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_wrap;
        ctl0_reg.enable && state_reg != DPW_IDLE && tick && count_reg >= reload_reg;
    endsequence

    property p_restart;
        @(posedge core_clk_i) disable iff (reset_i)
        s_wrap ##1 ctl0_reg.enable |-> count_reg == COUNT_RESTART;
    endproperty
    a_restart: assert property (p_restart) else $error("count did not restart at one");

    property p_first_pass;
        @(posedge core_clk_i) disable iff (reset_i)
        (state_reg == DPW_FIRST && tick && count_reg < reload_reg) |=>
            (state_reg == DPW_FIRST || !ctl0_reg.enable);
    endproperty
    a_first_pass: assert property (p_first_pass) else $error("first pass ended early");

    property p_period;
        @(posedge core_clk_i) disable iff (reset_i)
        s_wrap |=> reload_evt_o;
    endproperty
    a_period: assert property (p_period) else $error("reload event missing");

    property p_toggle;
        @(posedge core_clk_i) disable iff (reset_i)
        (ctl0_reg.enable && tick && count_reg == pwmv_reg && count_reg < reload_reg
            && state_reg != DPW_IDLE) |=> true_reg == ~$past(ctl0_reg.polarity);
    endproperty
    a_toggle: assert property (p_toggle) else $error("true output did not toggle");

    property p_pinsel;
        @(posedge core_clk_i) disable iff (reset_i)
        dual |=> comp_sel_o;
    endproperty
    a_pinsel: assert property (p_pinsel) else $error("pin not switched to complement");

    // ---------------------------------------------------------------
    // bus and output checks
    // ---------------------------------------------------------------
    sequence s_setup;
        psel_i && !penable_i;
    endsequence

    sequence s_bad_setup;
        psel_i && !penable_i && !decode_hit(paddr_i);
    endsequence

    property p_answer;
        @(posedge core_clk_i) disable iff (reset_i)
        s_setup |=> pready_o;
    endproperty
    a_answer: assert property (p_answer)
        else $error("no ready in access cycle");

    property p_slverr;
        @(posedge core_clk_i) disable iff (reset_i)
        s_bad_setup |=> pslverr_o;
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("unmapped address not flagged");

    property p_rd_unmapped;
        @(posedge core_clk_i) disable iff (reset_i)
        s_bad_setup ##0 !pwrite_i |=> prdata_o == 32'h0000_0000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not zero");

    property p_count_hold;
        @(posedge core_clk_i) disable iff (reset_i)
        (ctl0_reg.enable && !tick) |=> count_reg == $past(count_reg);
    endproperty
    a_count_hold: assert property (p_count_hold)
        else $error("count moved without prescale tick");

    property p_idle_level;
        @(posedge core_clk_i) disable iff (reset_i)
        !ctl0_reg.enable |=> true_reg == $past(ctl0_reg.polarity);
    endproperty
    a_idle_level: assert property (p_idle_level)
        else $error("stopped true output not at polarity level");

    property p_to_run;
        @(posedge core_clk_i) disable iff (reset_i)
        s_wrap |=> state_reg == DPW_RUN;
    endproperty
    a_to_run: assert property (p_to_run)
        else $error("pass state not run after wrap");

    property p_sel_off;
        @(posedge core_clk_i) disable iff (reset_i)
        !dual |=> !comp_sel_o;
    endproperty
    a_sel_off: assert property (p_sel_off)
        else $error("pin select set outside dual mode");

    property p_evt_enable;
        @(posedge core_clk_i) disable iff (reset_i)
        reload_evt_o |-> $past(ctl0_reg.enable);
    endproperty
    a_evt_enable: assert property (p_evt_enable)
        else $error("reload event while stopped");

    property p_no_overlap;
        @(posedge core_clk_i) disable iff (reset_i)
        (ctl0_reg.enable && dual && $past(ctl0_reg.enable, 3) && $past(dual, 3)) |->
            !(pwm_true_o != ctl0_reg.polarity && pwm_comp_o != ctl0_reg.polarity);
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("both outputs active together");
endmodule

// >>> sim/dpw_load_model.sv
// partner model: external switching stage watching both gate drives
`timescale 1ns/100ps
module dpw_load_model (
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    input  wire logic pol_i,
    input  wire logic gate_hi_i,
    input  wire logic gate_lo_i,
    output int        overlap_o,
    output int        gap_o
);
    int   run_cnt;
    logic hi_last;
    logic lo_last;
    // ---------------------------------------------------------------
    // gate watch
    // ---------------------------------------------------------------
    // shoot through and deadband gap
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            overlap_o <= 0;
            gap_o     <= 0;
            run_cnt   <= 0;
            hi_last   <= 1'b0;
            lo_last   <= 1'b0;
        end else begin
            hi_last <= gate_hi_i;
            lo_last <= gate_lo_i;
            run_cnt <= (gate_hi_i !== hi_last) ? 1 : run_cnt + 1;
            if (gate_hi_i === ~pol_i && gate_lo_i === ~pol_i)
                overlap_o <= overlap_o + 1;
            if (gate_lo_i === ~pol_i && lo_last === pol_i)
                gap_o <= run_cnt;
        end
    end
endmodule

// >>> sim/dual_pwm_deadband_timer_tb.sv
// testbench: dual pwm deadband timer with apb master and gate load model
`timescale 1ns/100ps
module dual_pwm_deadband_timer_tb;
    import dpw_pkg::*;
    logic        core_clk;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pwm_true;
    logic        pwm_comp;
    logic        comp_sel;
    logic        reload_evt;
    logic        pol;
    int          err_count;
    int          tests_run;
    int          cyc;
    int          overlap;
    int          gap;
    logic [31:0] rd;
    logic        er;

    dpw_timer dut_u (.core_clk_i(core_clk), .reset_i(reset), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pwm_true_o(pwm_true),
        .pwm_comp_o(pwm_comp), .comp_sel_o(comp_sel), .reload_evt_o(reload_evt));
    dpw_load_model load_u (.core_clk_i(core_clk), .reset_i(reset), .pol_i(pol),
        .gate_hi_i(pwm_true), .gate_lo_i(pwm_comp), .overlap_o(overlap), .gap_o(gap));

    always #5 core_clk = ~core_clk;
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input int tol,
                       input string msg);
        tests_run++;
        if ((^got === 1'bx) || (got > exp + tol) || (got + tol < exp)) begin
            err_count++;
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h0);
        cmp(rd, exp, 0, msg);
    endtask
    // cycles up to the next wrap pulse, with true active cycles counted
    task automatic wait_evt(output int len, output int act);
        len = 0;
        act = 0;
        do begin
            @(posedge core_clk);
            len++;
            if (pwm_true === ~pol)
                act++;
        end while (reload_evt !== 1'b1 && len < 20000);
    endtask
    task automatic print_verdict();
        $display("counts: tests_run=%0d err_count=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // timeout
    // ---------------------------------------------------------------
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 90000) begin
            err_count++;
            print_verdict();
        end
    end
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        int n, r, p, dd, c, len, act, ctl, ov0;
        core_clk = 1'b0;
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pol = 1'b0;
        err_count = 0;
        tests_run = 0;
        cyc = 0;
        void'($urandom(32'h5a1a));
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        rchk(CTL0_OFF, {24'h0, CTL0_RST}, "ctl0 reset");
        rchk(COUNT_OFF, {16'h0, COUNT_RST}, "count reset");
        rchk(PWMV_OFF, {16'h0, PWMV_RST}, "pwm reset");
        rchk(RELOAD_OFF, {16'h0, RELOAD_RST}, "reload reset");
        rchk(DEAD_OFF, {24'h0, DEAD_RST}, "dead reset");
        rchk(8'h3c, 32'h0, "unmapped read");
        cmp({31'h0, er}, 32'h1, 0, "unmapped error");
        cmp({31'h0, comp_sel}, 32'h0, 0, "pin select idle");
        $display("test reset values done");
        for (int t = 0; t < 4; t++) begin
            n  = $urandom_range(0, 2);
            r  = $urandom_range(40, 90);
            p  = $urandom_range(12, r - 12);
            dd = $urandom_range(2, 8);
            c  = (t % 2) ? $urandom_range(2, r - 5) : 1;
            pol = t[1];
            ctl = (int'(pol) << CTL0_POL_BIT) | (n << CTL0_PRES_LSB) | int'(MODE_LO_DUAL);
            // disable then set mode, prescale, polarity
            apb(1'b1, CTL0_OFF, 32'(ctl));
            apb(1'b1, CTL1_OFF, 32'(MODE_HI_DUAL) << CTL1_MODEHI_BIT);
            repeat (2) @(posedge core_clk);
            cmp({31'h0, comp_sel}, 32'h1, 0, "dual pin select");
            rchk(STAT_OFF, {29'h0, pol, pol, 1'b1}, "status idle");
            // count, compare, deadband, reload before enable
            apb(1'b1, COUNT_OFF, 32'(c));
            apb(1'b1, PWMV_OFF, 32'(p));
            apb(1'b1, DEAD_OFF, 32'(dd));
            apb(1'b1, RELOAD_OFF, 32'(r));
            rchk(PWMV_OFF, 32'(p), "pwm readback");
            ov0 = overlap;
            apb(1'b1, CTL0_OFF, 32'(ctl | (1 << CTL0_EN_BIT)));
            wait_evt(len, act);
            cmp(32'(len), 32'((r - c + 1) << n), (1 << n) + 6, "first period");
            wait_evt(len, act);
            cmp(32'(len), 32'(r << n), 0, "second period");
            wait_evt(len, act);
            cmp(32'(len), 32'(r << n), 0, "third period");
            cmp(32'(act), 32'((r - p + 1) << n), (1 << n) + 1, "true phase");
            cmp(32'(gap), 32'(dd), 1, "deadband gap");
            cmp(32'(overlap - ov0), 32'h0, 0, "no overlap");
            apb(1'b1, CTL0_OFF, 32'(ctl));
            $display("test pwm pass %0d done", t);
        end
        print_verdict();
    end
endmodule
